// ==== hw/pintc_controller.v ====
// fixed-priority interrupt controller with service instruction injection
`timescale 1ns/10ps
`include "pintc_defines.vh"
module pintc_controller (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // interrupt sources
  input wire [31:0] perReq,
  input wire stackReq,
  input wire [4:0] stackSlot,
  input wire dbgReq,
  input wire [4:0] dbgSlot,
  // ack to sources
  output reg [31:0] perAck,
  output reg stackAck,
  output reg dbgAck,
  // program memory read port
  output reg fetchReq,
  output reg [4:0] fetchAddr,
  input wire fetchValid,
  input wire [31:0] fetchData,
  // pipeline injection
  output reg injValid,
  output reg [31:0] injInstr,
  input wire injReady,
  // core status
  input wire coreHalted,
  input wire execCallint,
  input wire execRetint,
  output reg intEnabled,
  output reg haltRelease,
  output reg haltKeep,
  // peripheral space access
  input wire [1:0] periphAddr,
  input wire periphWrEn,
  input wire [31:0] periphWrData,
  input wire periphRdEn,
  output reg [31:0] periphRdData
);

  // ****************************************
  // states and storage
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_FETCH = 3'h2;
  localparam [2:0] ST_INJECT = 3'h4;

  reg [2:0] state;
  reg [31:0] enableMask;
  reg [31:0] haltWakeMask;
  reg [1:0] grantSrc;
  reg [4:0] grantIdx;
  reg grantWake;

  // ****************************************
  // helper functions
  // ****************************************
  // lowest set bit wins
  function [5:0] first_set;
    input [31:0] vec;
    integer i;
    begin
      first_set = 6'h20;
      for (i = 31; i >= 0; i = i - 1) begin
        if (vec[i]) begin
          first_set = i[5:0];
        end
      end
    end
  endfunction

  // one-hot word for a served slot
  function [31:0] slot_bit;
    input [4:0] slot;
    begin
      slot_bit = 32'h00000001 << slot;
    end
  endfunction

  // peripheral-space index match
  function reg_hit;
    input [1:0] addr;
    input [1:0] idx;
    begin
      reg_hit = (addr == idx);
    end
  endfunction

  // ****************************************
  // arbitration
  // ****************************************
  wire [31:0] perEligible = perReq & enableMask & {32{intEnabled}};
  wire [5:0] perWin = first_set(perEligible);
  wire perAny = ~perWin[5];
  wire stackAny = stackReq & intEnabled;
  reg candValid;
  reg [1:0] candSrc;
  reg [4:0] candIdx;

  always @* begin
    candValid = 1'b1;
    candSrc = `PINTC_SRC_PER;
    candIdx = perWin[4:0];
    if (dbgReq) begin
      candSrc = `PINTC_SRC_DBG;
      candIdx = dbgSlot;
    end else if (stackAny) begin
      candSrc = `PINTC_SRC_STACK;
      candIdx = stackSlot;
    end else if (!perAny) begin
      candValid = 1'b0;
    end
  end

  // ****************************************
  // grant, fetch and inject sequence
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      grantSrc <= `PINTC_SRC_PER;
      grantIdx <= 5'h00;
      grantWake <= 1'b0;
      fetchReq <= 1'b0;
      fetchAddr <= 5'h00;
      injValid <= 1'b0;
      injInstr <= 32'h00000000;
      perAck <= 32'h00000000;
      stackAck <= 1'b0;
      dbgAck <= 1'b0;
      haltRelease <= 1'b0;
      haltKeep <= 1'b0;
    end else begin
      perAck <= 32'h00000000;
      stackAck <= 1'b0;
      dbgAck <= 1'b0;
      haltRelease <= 1'b0;
      haltKeep <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (candValid) begin
            grantSrc <= candSrc;
            grantIdx <= candIdx;
            grantWake <= (candSrc != `PINTC_SRC_PER) | (|(haltWakeMask & slot_bit(candIdx)));
            fetchReq <= 1'b1;
            fetchAddr <= candIdx;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (fetchValid) begin
            fetchReq <= 1'b0;
            injInstr <= fetchData;
            injValid <= 1'b1;
            state <= ST_INJECT;
          end
        end
        ST_INJECT: begin
          if (injReady) begin
            injValid <= 1'b0;
            state <= ST_IDLE;
            if (grantSrc == `PINTC_SRC_DBG) begin
              dbgAck <= 1'b1;
            end else if (grantSrc == `PINTC_SRC_STACK) begin
              stackAck <= 1'b1;
            end else begin
              perAck <= slot_bit(grantIdx);
            end
            if (coreHalted) begin
              haltRelease <= grantWake;
              haltKeep <= ~grantWake;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          fetchReq <= 1'b0;
          injValid <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // global interrupt enable
  // ****************************************
  always @(posedge core_clk) begin
    if (rst) begin
      intEnabled <= 1'b1;
    end else if (execCallint) begin
      intEnabled <= 1'b0;
    end else if (execRetint) begin
      intEnabled <= 1'b1;
    end
  end

  // ****************************************
  // mask registers
  // ****************************************
  // write strobes per register index
  wire enableWrite = periphWrEn & reg_hit(periphAddr, `PINTC_ENABLE_MASK_ADDR);
  wire wakeWrite = periphWrEn & reg_hit(periphAddr, `PINTC_HALT_WAKE_MASK_ADDR);

  always @(posedge core_clk) begin
    if (rst) begin
      enableMask <= `PINTC_ENABLE_MASK_RESET;
      haltWakeMask <= `PINTC_HALT_WAKE_MASK_RESET;
      periphRdData <= 32'h00000000;
    end else begin
      if (enableWrite) begin
        enableMask <= periphWrData;
      end
      if (wakeWrite) begin
        haltWakeMask <= periphWrData;
      end
      if (periphRdEn) begin
        case (periphAddr)
          `PINTC_ENABLE_MASK_ADDR: periphRdData <= enableMask;
          `PINTC_HALT_WAKE_MASK_ADDR: periphRdData <= haltWakeMask;
          default: periphRdData <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // pintc_controller

// ==== pkg/pintc_defines.vh ====
// constants of the fixed-priority interrupt controller
// Overview of operation
// - fixed priority, index 0 wins
// - grant injects one service instruction only
// - service instruction fetched from words 0..31
// - debug beats stack beats peripheral requests
// - single-instruction interrupt completes as fast
// - interrupt-call disables interrupts, pushes pc
// - interrupt-return re-enables interrupts
// - plain call or jump keeps interrupts enabled
// - enable and run masks, 32 bits, readable
// - mask bit n governs interrupt n
// - only enabled interrupts served; reset zero (stack and debug requests bypass the enable mask, debug also the global enable)
// - halted plus run bit releases halt
// - halted without run bit stays halted for peripheral grants; stack and debug grants always release halt
`ifndef PINTC_DEFINES_VH
`define PINTC_DEFINES_VH
// peripheral-space register indices
`define PINTC_ADDR_W 2
`define PINTC_ENABLE_MASK_ADDR 2'h0
`define PINTC_HALT_WAKE_MASK_ADDR 2'h1
`define PINTC_ENABLE_MASK_RESET 32'h00000000
`define PINTC_HALT_WAKE_MASK_RESET 32'h00000000
// sizes
`define PINTC_NUM_IRQ 32
`define PINTC_SLOT_W 5
`define PINTC_INSTR_W 32
// source codes
`define PINTC_SRC_PER 2'h0
`define PINTC_SRC_STACK 2'h1
`define PINTC_SRC_DBG 2'h2
`endif

// ==== testbench/pintc_checker.sv ====
// assertions on the interrupt controller ports
`timescale 1ns/10ps
module pintc_checker (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // watched outputs and core status
  input wire fetchReq,
  input wire fetchValid,
  input wire injValid,
  input wire injReady,
  input wire stackAck,
  input wire dbgAck,
  input wire intEnabled,
  input wire execCallint,
  input wire execRetint,
  input wire coreHalted,
  input wire haltRelease,
  input wire haltKeep,
  input wire [31:0] perAck
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence sTake; injValid && injReady; endsequence
  sequence sAck; !injValid && (|perAck || stackAck || dbgAck); endsequence
  AST_FETCH: assert property (fetchReq && !fetchValid |=> fetchReq) else $error("fetch");
  AST_INJ: assert property (fetchReq && fetchValid |=> injValid) else $error("inject");
  AST_HOLD: assert property (injValid && !injReady |=> injValid) else $error("hold");
  AST_ACK: assert property (sTake |=> sAck) else $error("ack");
  AST_ONE: assert property ($onehot0({perAck, stackAck, dbgAck})) else $error("acks");
  AST_CALL: assert property (execCallint |=> !intEnabled) else $error("call");
  AST_RET: assert property (execRetint && !execCallint |=> intEnabled) else $error("ret");
  AST_KEEP: assert property (!execCallint && !execRetint |=> $stable(intEnabled))
    else $error("enable");
  AST_HALT: assert property (
    haltRelease |-> !haltKeep && $past(injValid && injReady))
    else $error("halt");
  AST_KEEPH: assert property (
    haltKeep |-> !haltRelease && $past(injValid && injReady))
    else $error("keep");
  AST_WAKE: assert property (
    haltRelease || haltKeep |-> $past(coreHalted))
    else $error("wake");
endmodule // pintc_checker
bind pintc_controller pintc_checker chk (.*);

// ==== testbench/pintc_pmem.sv ====
// program memory and pipeline model facing the controller
`timescale 1ns/10ps
module pintc_pmem (
  input wire core_clk,
  input wire fetchReq,
  input wire [4:0] fetchAddr,
  output logic fetchValid,
  output logic [31:0] fetchData,
  output logic injReady
);
  initial {fetchValid, fetchData, injReady} = '0;
  always @(negedge core_clk) begin
    injReady <= 1'($urandom % 2);
    if (fetchReq && !fetchValid && ($urandom % 2)) begin
      fetchValid <= 1'b1;
      fetchData <= {16'hC0DE, 11'h000, fetchAddr};
    end else begin
      fetchValid <= 1'b0;
      fetchData <= ~fetchData;
    end
  end
endmodule // pintc_pmem

// ==== testbench/tb_priority_interrupt_controller.sv ====
// self-checking bench of the interrupt controller
`timescale 1ns/10ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_priority_interrupt_controller;
  logic core_clk = 0, rst = 1, stackReq = 0, dbgReq = 0, coreHalted = 0;
  logic execCallint = 0, execRetint = 0, periphWrEn = 0, periphRdEn = 0, rdPend = 0;
  logic fetchReq, fetchValid, injValid, injReady, stackAck, dbgAck;
  logic intEnabled, haltRelease, haltKeep;
  logic [1:0] periphAddr = 0;
  logic [4:0] stackSlot = 0, dbgSlot = 0, fetchAddr;
  logic [31:0] perReq = 0, periphWrData = 0, perAck, fetchData, injInstr, periphRdData, m, r;
  logic [35:0] expQ[$];
  int miscompares = 0, total_checks = 0;
  always #4 core_clk = ~core_clk;
  pintc_controller dut (.*);
  pintc_pmem mem (.*);
  task chk(input logic [35:0] v);
    logic [35:0] e;
    `CHK("queued", 1'b1, expQ.size() != 0)
    e = (expQ.size() != 0) ? expQ.pop_front() : 36'h0;
    `CHK("out", e, v)
  endtask
  always @(posedge core_clk) begin
    rdPend <= periphRdEn;
    if (rdPend) chk({4'h0, periphRdData});
    if (injValid && injReady) chk({4'h0, injInstr});
    if (|{perAck, stackAck, dbgAck})
      chk({haltRelease, haltKeep, dbgAck, stackAck, perAck});
  end
  // sources drop a request once it is acknowledged
  always @(negedge core_clk) begin
    if (|perAck) perReq <= perReq & ~perAck;
    if (stackAck) stackReq <= 1'b0;
    if (dbgAck) dbgReq <= 1'b0;
  end
  task acc(input logic [1:0] a, input logic [31:0] d, input logic w);
    @(negedge core_clk) {periphAddr, periphWrData, periphWrEn, periphRdEn} = {a, d, w, !w};
    @(negedge core_clk) {periphWrEn, periphRdEn} = 2'b00;
  endtask
  task note(input logic [4:0] s, input logic [35:0] a);
    expQ.push_back({16'hC0DE, 11'h000, s});
    expQ.push_back(a);
  endtask
  task print_verdict;
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    print_verdict;
  end
  initial begin
    void'($urandom(21466));
    repeat (6) @(negedge core_clk);
    rst = 0;
    expQ = '{36'h0, 36'h0};
    acc(2'h0, 32'h0, 1'b0);
    acc(2'h1, 32'h0, 1'b0);
    m = $urandom | 32'h80000001;
    r = $urandom | 32'h80000001;
    acc(2'h0, m, 1'b1);
    expQ.push_back({4'h0, m});
    acc(2'h0, 32'h0, 1'b0);
    acc(2'h1, r, 1'b1);
    expQ.push_back({4'h0, r});
    acc(2'h1, 32'h0, 1'b0);
    acc(2'h2, 32'hFFFFFFFF, 1'b1);
    expQ.push_back(36'h0);
    acc(2'h2, 32'h0, 1'b0);
    expQ.push_back({4'h0, m});
    acc(2'h0, 32'h0, 1'b0);
    for (int i = 0; i < 32; i++) if (m[i] & r[i]) note(5'(i), {4'h0, 32'h1 << i});
    perReq = r;
    repeat (400) @(negedge core_clk);
    `CHK("masked", r & ~m, perReq)
    perReq = 32'h0;
    acc(2'h1, 32'h4, 1'b1);
    acc(2'h0, 32'h6, 1'b1);
    {coreHalted, dbgSlot, stackSlot} = {1'b1, 5'h07, 5'h09};
    note(5'h07, 36'hA00000000);
    note(5'h09, 36'h900000000);
    note(5'h01, 36'h400000002);
    note(5'h02, 36'h800000004);
    {dbgReq, stackReq, perReq} = {2'b11, 32'h6};
    repeat (100) @(negedge core_clk);
    {coreHalted, execCallint} = 2'b01;
    @(negedge core_clk) execCallint = 1'b0;
    {stackReq, perReq} = {1'b1, 32'h2};
    repeat (30) @(negedge core_clk);
    note(5'h09, 36'h100000000);
    note(5'h01, 36'h000000002);
    execRetint = 1'b1;
    @(negedge core_clk) execRetint = 1'b0;
    repeat (60) @(negedge core_clk);
    `CHK("left", 0, expQ.size())
    print_verdict;
  end
endmodule // tb_priority_interrupt_controller
